// ### hdl/pdad_pkg.sv
// Shared constants and carriers for the power-down and ALU-op decoder.
// Assumes one 50 MHz clock and an AHB-Lite master with single word transfers.
package pdad_pkg;

    // ==========================================================
    // Opcode encodings (14-bit program word)
    localparam logic [13:0] OP_HALT         = 14'h0063;
    localparam logic [13:0] OP_DOG_KICK     = 14'h0064;
    localparam logic [5:0]  OP_INVERT       = 6'h09;
    localparam logic [5:0]  OP_DECREMENT    = 6'h03;
    localparam logic [5:0]  OP_ROTATE_RIGHT = 6'h0C;
    localparam logic [5:0]  OP_FILE_MINUS   = 6'h02;
    localparam logic [4:0]  OP_LIT_MINUS    = 5'h1E;
    localparam int          OP_DEST_BIT     = 7;

    // ==========================================================
    // Register byte offsets
    localparam logic [9:0] REG_INSTR    = 10'h000;
    localparam logic [9:0] REG_ACC      = 10'h004;
    localparam logic [9:0] REG_FLAGS    = 10'h008;
    localparam logic [9:0] REG_CTRL     = 10'h00C;
    localparam logic [9:0] REG_WDOG     = 10'h010;
    localparam logic [9:0] REG_IRQ_STAT = 10'h014;
    localparam logic [9:0] REG_IRQ_MASK = 10'h018;
    localparam logic       FILE_SEL     = 1'b1;
    localparam int         FILE_SEL_BIT = 9;

    // ==========================================================
    // Field positions
    localparam int F_CARRY    = 0;
    localparam int F_HALF     = 1;
    localparam int F_ZERO     = 2;
    localparam int F_PD       = 3;
    localparam int F_EXPIRY   = 4;
    localparam int C_WDOG_EN  = 0;
    localparam int C_PORT_LO  = 8;
    localparam int C_OE_LO    = 16;
    localparam int W_PRE_LO   = 8;
    localparam int W_SLEEP    = 16;
    localparam int I_HALT     = 0;
    localparam int I_EXPIRY   = 1;
    localparam int I_WAKE     = 2;

    // ==========================================================
    // Reset values
    localparam logic       RST_PD_FLAG  = 1'b1;
    localparam logic       RST_EXP_FLAG = 1'b1;
    localparam logic [7:0] WDOG_CLEAR   = 8'h00;
    localparam logic [7:0] WDOG_LAST    = 8'hFF;

    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } pdad_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } pdad_ahb_rsp_t;

endpackage : pdad_pkg

// ### hdl/pdad_core.sv
// Decoder and executor for halt, watchdog kick and five ALU ops, with an
// AHB-Lite register port, 128 file registers and a watchdog.
// Assumes synchronous inputs and a master that issues single word transfers.
//
// Contract
// RL1: Halt opcode enters power-down and stops the oscillator driver and execution.
// RL2: Halt with watchdog on clears counter to 00h; it keeps counting asleep.
// RL3: Halt also zeroes the watchdog prescaler.
// RL4: Halt clears the power-down flag and sets the expiry flag.
// RL5: During power-down every port pin keeps its drive and enable state.
// RL6: Outside circuit holds the master clear pin high during power-down.
// RL7: Watchdog expiry reset never drives the master clear pin; input only.
// RL8: Kick opcode clears counter and prescaler, sets expiry and power-down flags.
// RL9: File ops address files 0-127; destination bit 0 accumulator, 1 file.
// RL10: Invert op writes complement of file to destination; zero flag only.
// RL11: Decrement op writes file minus one to destination; zero flag only.
// RL12: Rotate right through carry; old carry to bit 7, bit 0 to carry.
// RL13: Literal minus accumulator into accumulator; carry, half borrow, zero.
// RL14: Subtraction carry is inverted borrow: 1 if result not negative.
// RL15: File minus accumulator to destination; carry, half borrow, zero updated.
// RL16: Every instruction is one 14-bit word and completes in one cycle.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pdad_core (
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_nrst,
    // Register bus
    input  wire pdad_pkg::pdad_ahb_req_t i_ahb,
    output var  pdad_pkg::pdad_ahb_rsp_t o_ahb,
    // Master clear pin, three-signal form
    input  wire logic                    i_master_clear_pin,
    output var  logic                    o_master_clear_pin,
    output var  logic                    o_master_clear_pin_oe,
    // Port pins, oscillator and events
    output var  logic [7:0]              o_port_out,
    output var  logic [7:0]              o_port_oe,
    output var  logic                    o_osc_enable,
    output var  logic                    o_wdog_reset,
    output var  logic                    o_irq
);
    import pdad_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [127:0][7:0] files;
        logic [7:0]        acc;
        logic              carry;
        logic              half;
        logic              zero;
        logic              pd_flag;
        logic              exp_flag;
        logic              wdog_en;
        logic [7:0]        wdog;
        logic [7:0]        prescale;
        logic              sleeping;
        logic [7:0]        port_out;
        logic [7:0]        port_oe;
        logic [2:0]        irq_stat;
        logic [2:0]        irq_mask;
        logic              wr_pend;
        logic              rd_pend;
        logic [9:0]        addr;
        logic [31:0]       hrdata;
        logic              irq;
        logic              wdog_rst;
        logic              osc_en;
    } pdad_state_t;

    pdad_state_t st_reg;
    pdad_state_t st_next;

    // ==========================================================
    // Helpers
    // Returns {carry, half, result} of a - b, carry as inverted borrow
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b};
        low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        sub8 = {~full[8], ~low[4], full[7:0]}; // see RL14
    endfunction

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [13:0] op;
        logic [6:0]  fsel;
        logic [7:0]  fval;
        logic [7:0]  res;
        logic [9:0]  sr;
        logic        wr_dest;
        logic        do_exec;
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic [31:0] rd;
        logic        wdog_tick;
        logic        dog_clr;
        op        = 14'h0000;
        fsel      = 7'h00;
        fval      = 8'h00;
        res       = 8'h00;
        sr        = 10'h000;
        wr_dest   = 1'b0;
        do_exec   = 1'b0;
        ev        = 3'h0;
        clr       = 3'h0;
        rd        = 32'h0000_0000;
        wdog_tick = 1'b0;
        dog_clr   = 1'b0;
        st_next   = st_reg;

        // Address phase capture; zero wait states
        st_next.wr_pend = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready && i_ahb.hwrite;
        st_next.rd_pend = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready && !i_ahb.hwrite;
        if (i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready) begin
            st_next.addr = i_ahb.haddr[9:0];
        end

        // Read data sampled at the address phase edge
        if (i_ahb.haddr[FILE_SEL_BIT] == FILE_SEL) begin
            rd = {24'h000000, st_reg.files[i_ahb.haddr[8:2]]};
        end else begin
            case (i_ahb.haddr[9:0])
                REG_ACC:      rd = {24'h000000, st_reg.acc};
                REG_FLAGS:    rd = {27'h0, st_reg.exp_flag, st_reg.pd_flag, st_reg.zero,
                                    st_reg.half, st_reg.carry};
                REG_CTRL:     rd = {8'h00, st_reg.port_oe, st_reg.port_out, 7'h00,
                                    st_reg.wdog_en};
                REG_WDOG:     rd = {15'h0, st_reg.sleeping, st_reg.prescale, st_reg.wdog};
                REG_IRQ_STAT: rd = {29'h0, st_reg.irq_stat};
                REG_IRQ_MASK: rd = {29'h0, st_reg.irq_mask};
                default:      rd = 32'h0000_0000;
            endcase
        end
        // Hold read data through the data phase; idle cycles leave it alone
        if (i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready && !i_ahb.hwrite) begin
            st_next.hrdata = rd;
        end

        // Data phase writes
        if (st_reg.wr_pend) begin
            if (st_reg.addr[FILE_SEL_BIT] == FILE_SEL) begin
                st_next.files[st_reg.addr[8:2]] = i_ahb.hwdata[7:0];
            end else begin
                case (st_reg.addr)
                    REG_INSTR: begin
                        op      = i_ahb.hwdata[13:0]; // see RL16
                        // Asleep the core fetches nothing, so the word is dropped
                        do_exec = !st_reg.sleeping; // see RL1
                    end
                    REG_ACC: st_next.acc = i_ahb.hwdata[7:0];
                    REG_FLAGS: begin
                        st_next.carry = i_ahb.hwdata[F_CARRY];
                        st_next.half  = i_ahb.hwdata[F_HALF];
                        st_next.zero  = i_ahb.hwdata[F_ZERO];
                    end
                    REG_CTRL: begin
                        st_next.wdog_en = i_ahb.hwdata[C_WDOG_EN];
                        // Pins frozen while asleep
                        if (!st_reg.sleeping) begin
                            st_next.port_out = i_ahb.hwdata[C_PORT_LO+:8]; // see RL5
                            st_next.port_oe  = i_ahb.hwdata[C_OE_LO+:8]; // see RL5
                        end
                    end
                    REG_IRQ_STAT: clr = i_ahb.hwdata[2:0];
                    REG_IRQ_MASK: st_next.irq_mask = i_ahb.hwdata[2:0];
                    default: ;
                endcase
            end
        end

        // Watchdog runs asleep too; execution below may override the increment
        if (st_reg.wdog_en) begin
            st_next.prescale = st_reg.prescale + 8'h01;
            wdog_tick        = (st_reg.prescale == WDOG_LAST);
            if (wdog_tick) begin
                st_next.wdog = st_reg.wdog + 8'h01;
            end
        end
        st_next.wdog_rst = 1'b0;
        // Halt or kick this cycle cancels an expiry landing on the same edge
        dog_clr = do_exec && (op == OP_HALT || op == OP_DOG_KICK);
        if (wdog_tick && st_reg.wdog == WDOG_LAST && !dog_clr) begin
            st_next.exp_flag = 1'b0;
            ev[I_EXPIRY]     = 1'b1;
            if (st_reg.sleeping) begin
                st_next.sleeping = 1'b0;
                ev[I_WAKE]       = 1'b1;
            end else begin
                st_next.wdog_rst = 1'b1; // see RL7
            end
        end

        // Master clear low wakes a sleeping core
        if (st_reg.sleeping && !i_master_clear_pin) begin // see RL6
            st_next.sleeping = 1'b0;
            ev[I_WAKE]       = 1'b1;
        end

        // Instruction execution, one word per cycle
        fsel    = op[6:0]; // see RL9
        fval    = st_reg.files[fsel];
        wr_dest = op[OP_DEST_BIT];
        if (do_exec) begin
            if (op == OP_HALT) begin
                st_next.wdog     = WDOG_CLEAR; // see RL2
                st_next.prescale = WDOG_CLEAR; // see RL3
                st_next.pd_flag  = 1'b0; // see RL4
                st_next.exp_flag = 1'b1; // see RL4
                st_next.sleeping = 1'b1; // see RL1
                ev[I_HALT]       = 1'b1;
            end else if (op == OP_DOG_KICK) begin
                st_next.wdog     = WDOG_CLEAR; // see RL8
                st_next.prescale = WDOG_CLEAR; // see RL8
                st_next.pd_flag  = 1'b1; // see RL8
                st_next.exp_flag = 1'b1; // see RL8
            end else if (op[13:9] == OP_LIT_MINUS) begin
                sr            = sub8(op[7:0], st_reg.acc); // see RL13
                st_next.acc   = sr[7:0];
                st_next.carry = sr[9];
                st_next.half  = sr[8];
                st_next.zero  = is_zero(sr[7:0]);
            end else begin
                case (op[13:8])
                    OP_INVERT, OP_DECREMENT, OP_ROTATE_RIGHT, OP_FILE_MINUS: begin
                        case (op[13:8])
                            OP_INVERT: begin
                                res          = ~fval; // see RL10
                                st_next.zero = is_zero(res);
                            end
                            OP_DECREMENT: begin
                                res          = fval - 8'h01; // see RL11
                                st_next.zero = is_zero(res);
                            end
                            OP_ROTATE_RIGHT: begin
                                res           = {st_reg.carry, fval[7:1]}; // see RL12
                                st_next.carry = fval[0];
                            end
                            default: begin
                                sr            = sub8(fval, st_reg.acc); // see RL15
                                res           = sr[7:0];
                                st_next.carry = sr[9];
                                st_next.half  = sr[8];
                                st_next.zero  = is_zero(res);
                            end
                        endcase
                        if (wr_dest) begin
                            st_next.files[fsel] = res; // see RL9
                        end else begin
                            st_next.acc = res;
                        end
                    end
                    default: ; // Other opcodes belong to other units
                endcase
            end
        end

        // Sticky events; set beats a same-cycle clear
        st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
        st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
        st_next.osc_en   = !st_next.sleeping; // see RL1
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            // Both status flags come up set so software can spot a cold start
            st_reg          <= '0;
            st_reg.pd_flag  <= RST_PD_FLAG;
            st_reg.exp_flag <= RST_EXP_FLAG;
            st_reg.osc_en   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs, from flops or tied constants
    always_comb begin
        o_ahb.hreadyout = 1'b1;
        o_ahb.hresp     = 1'b0;
        o_ahb.hrdata    = st_reg.hrdata;
    end

    // Pin is never driven, so an expiry cannot pull it low
    assign o_master_clear_pin    = 1'b0; // see RL7
    assign o_master_clear_pin_oe = 1'b0; // see RL7
    assign o_port_out            = st_reg.port_out;
    assign o_port_oe             = st_reg.port_oe;
    assign o_osc_enable          = st_reg.osc_en;
    assign o_wdog_reset          = st_reg.wdog_rst;
    assign o_irq                 = st_reg.irq;

endmodule // pdad_core

`default_nettype wire

// ### tb/pdad_core_monitor.sv
// Port checker for the halt, kick and ALU decoder.
// Assumes it is bound into every pdad_core instance.
`timescale 1ns/1ps
`default_nettype none
module pdad_core_monitor
    import pdad_pkg::*;
(
    input wire logic                    i_clock,
    input wire logic                    i_nrst,
    input wire pdad_pkg::pdad_ahb_req_t i_ahb,
    input wire pdad_pkg::pdad_ahb_rsp_t o_ahb,
    input wire logic                    i_master_clear_pin,
    input wire logic                    o_master_clear_pin_oe,
    input wire logic [7:0]              o_port_out,
    input wire logic [7:0]              o_port_oe,
    input wire logic                    o_osc_enable,
    input wire logic                    o_wdog_reset
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // ==========================================================
    // Bus sequences
    sequence addr_ph(logic w, logic [9:0] a);
        i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready && i_ahb.hwrite == w
            && i_ahb.haddr[9:0] == a;
    endsequence
    sequence instr_wr(logic [13:0] op);
        addr_ph(1'b1, REG_INSTR) ##1 i_ahb.hwdata[13:0] == op;
    endsequence
    AST_HALT_SLEEP: assert property (instr_wr(OP_HALT) |=> !o_osc_enable [*3])
        else $error("oscillator still running after halt");
    AST_KICK_QUIET: assert property (instr_wr(OP_DOG_KICK) |=> !o_wdog_reset [*8])
        else $error("watchdog reset soon after kick");
    AST_PORTS_HELD: assert property (!o_osc_enable && !$past(o_osc_enable) |->
        $stable(o_port_out) && $stable(o_port_oe)) else $error("port changed while asleep");
    AST_PIN_INPUT: assert property (!o_master_clear_pin_oe)
        else $error("master clear pin driven");
    AST_WDOG_NO_PIN: assert property (o_wdog_reset |-> !o_master_clear_pin_oe
        && $past(o_osc_enable)) else $error("bad watchdog reset");
    AST_READY: assert property (o_ahb.hreadyout && !o_ahb.hresp)
        else $error("bus not ready or not okay");
    AST_ACC_WIDTH: assert property (addr_ph(1'b0, REG_ACC) |=> o_ahb.hrdata[31:8] == 24'h0)
        else $error("accumulator read wider than a byte");
    AST_WAKE: assert property (!o_osc_enable && !i_master_clear_pin |-> ##[1:2] o_osc_enable)
        else $error("no wake on master clear");
endmodule // pdad_core_monitor

bind pdad_core pdad_core_monitor u_mon (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ahb(i_ahb), .o_ahb(o_ahb),
    .i_master_clear_pin(i_master_clear_pin), .o_master_clear_pin_oe(o_master_clear_pin_oe),
    .o_port_out(o_port_out), .o_port_oe(o_port_oe), .o_osc_enable(o_osc_enable),
    .o_wdog_reset(o_wdog_reset)
);
`default_nettype wire

// ### tb/pdad_core_test.sv
// Self-checking bench for the decoder, driving its AHB-Lite port.
// Assumes the slave answers with hreadyout and reads return next edge.
`timescale 1ns/1ps
`default_nettype none
module pdad_core_test;
    import pdad_pkg::*;
    logic          i_clock = 1'b0;
    logic          i_nrst  = 1'b0;
    logic          master_clear_pin    = 1'b1;
    logic          rd_ph   = 1'b0;
    pdad_ahb_req_t req     = '0;
    pdad_ahb_rsp_t rsp;
    logic [7:0]    port_out, port_oe, fv, av, r;
    logic          osc, irq, d, master_clear_pin_o, master_clear_pin_oe, wdrst;
    logic [2:0]    fl;
    logic [13:0]   opc;
    logic [31:0]   expq[$];
    logic [5:0]    opt[4] = '{OP_INVERT, OP_DECREMENT, OP_ROTATE_RIGHT, OP_FILE_MINUS};
    int            error_cnt = 0, check_count = 0, seed = 68060, f, op, cyc;

    pdad_core dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_ahb(req), .o_ahb(rsp),
        .i_master_clear_pin(master_clear_pin), .o_master_clear_pin(master_clear_pin_o),
        .o_master_clear_pin_oe(master_clear_pin_oe),
        .o_port_out(port_out), .o_port_oe(port_oe), .o_osc_enable(osc),
        .o_wdog_reset(wdrst), .o_irq(irq));

    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) req.hready <= rsp.hreadyout;
    // Read data is judged at the data-phase edge only
    always @(posedge i_clock) if (rd_ph === 1'b1 && rsp.hreadyout === 1'b1)
        chk(rsp.hrdata, expq.pop_front());

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // Bus master
    task hold;
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (rsp.hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            final_report();
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] dat);
        req.hsel <= 1'b1; req.htrans <= 2'b10; req.haddr <= a;
        req.hwrite <= w; req.hsize <= 3'b010;
        hold();
        req.hsel <= 1'b0; req.htrans <= 2'b00; req.hwdata <= dat; rd_ph <= ~w;
        hold();
        rd_ph <= 1'b0;
    endtask
    task wr(input logic [9:0] a, input logic [31:0] dat);
        xfer(1'b1, 32'(a), dat);
    endtask
    task rd(input logic [9:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        xfer(1'b0, 32'(a), 32'h0);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        rd(REG_FLAGS, 32'h18);
        rd(10'h100, 32'h0);
        for (int i = 0; i < 20; i++) begin
            op = i % 5;
            d = 1'((i / 5) % 2);
            f = $random(seed) & 127;
            fv = 8'($random(seed));
            av = (i >= 10) ? fv : 8'($random(seed));
            fl = 3'($random(seed));
            wr(10'h200 + 10'(f * 4), 32'(fv));
            wr(REG_ACC, 32'(av));
            wr(REG_FLAGS, 32'(fl));
            opc = (op < 4) ? {opt[op], d, 7'(f)} : {OP_LIT_MINUS, d, fv};
            wr(REG_INSTR, 32'(opc));
            case (op)
                0: r = ~fv;
                1: r = fv - 8'h01;
                2: r = {fl[0], fv[7:1]};
                default: r = fv - av;
            endcase
            if (op == 2) fl[0] = fv[0];
            else fl[2] = (r == 8'h00);
            if (op >= 3) fl[1:0] = {fv[3:0] >= av[3:0], fv >= av};
            rd(REG_ACC, 32'((op == 4 || !d) ? r : av));
            rd(10'h200 + 10'(f * 4), 32'((op < 4 && d) ? r : fv));
            rd(REG_FLAGS, {27'h0, 2'b11, fl});
        end
        wr(REG_CTRL, 32'h003C_A501);
        wr(REG_IRQ_MASK, 32'h1);
        repeat (3) @(posedge i_clock);
        wr(REG_INSTR, 32'(OP_HALT));
        rd(REG_WDOG, 32'h0001_0000);
        rd(REG_FLAGS, {27'h0, 2'b10, fl});
        wr(REG_CTRL, 32'h00FF_0001);
        chk(32'(osc), 32'h0);
        chk(32'({port_oe, port_out}), 32'h3CA5);
        chk(32'(irq), 32'h1);
        rd(REG_IRQ_STAT, 32'h1);
        master_clear_pin <= 1'b0;
        @(posedge i_clock);
        master_clear_pin <= 1'b1;
        repeat (3) @(posedge i_clock);
        chk(32'(osc), 32'h1);
        rd(REG_IRQ_STAT, 32'h5);
        wr(REG_IRQ_STAT, 32'h7);
        repeat (2) @(posedge i_clock);
        chk(32'(irq), 32'h0);
        wr(REG_INSTR, 32'(OP_DOG_KICK));
        rd(REG_WDOG, 32'h0);
        rd(REG_FLAGS, {27'h0, 2'b11, fl});
        // Watchdog left running; expiry while awake pulses the reset output
        cyc = 0;
        while (wdrst !== 1'b1 && cyc < 70000) begin
            @(posedge i_clock);
            cyc++;
        end
        if (cyc >= 70000) begin
            error_cnt++;
            final_report();
        end
        chk(32'({master_clear_pin_oe, master_clear_pin_o}), 32'h0);
        rd(REG_FLAGS, {27'h0, 2'b01, fl});
        rd(REG_IRQ_STAT, 32'h2);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        rd(REG_FLAGS, 32'h18);
        final_report();
    end
endmodule // pdad_core_test
`default_nettype wire
